/* common/npr_pkg.sv */
// Purpose: shared constants and types for the next page register block
// Assumes: byte-wide switch register port, 16-bit pages split in two bytes
// Notes:   page layout follows the link codeword bit order, msb first
package npr_pkg;

  // directly addressed switch registers
  localparam logic [7:0] NPR_ADDR_SEL  = 8'h6E; // table and port select
  localparam logic [7:0] NPR_ADDR_OFS  = 8'h6F; // indirect byte offset
  localparam logic [7:0] NPR_ADDR_DATA = 8'hA0; // indirect byte data

  // select register fields
  localparam int         NPR_GRP_MSB   = 7;
  localparam int         NPR_GRP_LSB   = 5;
  localparam int         NPR_PORT_MSB  = 3;
  localparam int         NPR_PORT_LSB  = 0;
  localparam logic [2:0] NPR_GRP_ENERGY = 3'h1;
  localparam logic [3:0] NPR_PORT_LOW  = 4'h3; // first port of the group
  localparam int         NPR_PORT_CNT  = 2;    // ports 3 and 4

  // indirect offsets
  localparam logic [7:0] NPR_OFS_TX_HI = 8'h0E;
  localparam logic [7:0] NPR_OFS_TX_LO = 8'h0F;
  localparam logic [7:0] NPR_OFS_LP_HI = 8'h10;
  localparam logic [7:0] NPR_OFS_LP_LO = 8'h11;

  // field positions inside the upper byte of a page
  localparam int         NPR_HI_MORE   = 7;
  localparam int         NPR_HI_MSG    = 5;
  localparam int         NPR_HI_COMPLY = 4;
  localparam int         NPR_HI_CODE_MSB = 2;

  // one next page, bit 15 down to bit 0
  typedef struct packed {
    logic        more_pages_flag;   // 15
    logic        ack;               // 14
    logic        message_page_flag; // 13
    logic        comply_ack_flag;   // 12
    logic        toggle;            // 11
    logic [10:0] code;              // 10..0
  } npr_page_t;

  // reset values
  localparam npr_page_t  NPR_TX_RST = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 11'h000};
  localparam npr_page_t  NPR_LP_RST = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 11'h000};
  localparam logic [7:0] NPR_SEL_RST = 8'h00;
  localparam logic [7:0] NPR_OFS_RST = 8'h00;

endpackage : npr_pkg

/* hdl/npr_port.sv */
// Purpose: per-port transmit and partner next page storage
// Assumes: write strobes are already decoded for this port
// Notes:   toggle is owned by hardware, software writes never touch it
`timescale 1ns/100ps
module npr_port
  import npr_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // software byte writes
  input  wire logic       wr_hi,
  input  wire logic       wr_lo,
  input  wire logic [7:0] wdata,
  // link side events
  input  wire logic       start,
  input  wire logic       base_toggle,
  input  wire logic       sent,
  input  wire logic       rx_valid,
  input  wire npr_page_t  rx_page,
  // stored pages
  output npr_page_t       tx_page_q,
  output npr_page_t       lp_page_q
);

  npr_page_t tx_page_d;
  npr_page_t lp_page_d;

  // next values of both pages
  always_comb begin
    tx_page_d = tx_page_q;
    lp_page_d = lp_page_q;
    if (wr_hi) begin
      tx_page_d.more_pages_flag   = wdata[NPR_HI_MORE];
      tx_page_d.message_page_flag = wdata[NPR_HI_MSG];
      tx_page_d.comply_ack_flag   = wdata[NPR_HI_COMPLY];
      tx_page_d.code[10:8]        = wdata[NPR_HI_CODE_MSB:0];
    end
    if (wr_lo) begin
      tx_page_d.code[7:0] = wdata;
    end
    // a fresh sequence outranks a page sent in the same cycle
    if (start) begin
      tx_page_d.toggle = ~base_toggle;
    end else if (sent) begin
      tx_page_d.toggle = ~tx_page_q.toggle;
    end
    tx_page_d.ack = 1'b0;
    if (rx_valid) begin
      lp_page_d = rx_page;
    end
  end

  // page storage
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_page_q <= NPR_TX_RST;
      lp_page_q <= NPR_LP_RST;
    end else begin
      tx_page_q <= tx_page_d;
      lp_page_q <= lp_page_d;
    end
  end

endmodule : npr_port

/* hdl/npr_regs.sv */
// Purpose: indirect next page registers for the energy efficient ethernet ports
// Assumes: one register access per cycle, reads answered one cycle later
// Notes:   only ports 3 and 4 respond; other selections read zero
// Function
// - tx page bit 15 is writable more-pages flag, resets to 0.
// - tx page bit 13 is writable message page flag, resets to 1.
// - tx page bit 12 is writable comply acknowledge flag, resets to 0.
// - bit 11 is hardware toggle, inverse of previous exchanged toggle.
// - first next page toggle is inverse of base codeword bit 11.
// - bits 10 to 0 are a writable 11-bit code field.
// - selected indirect byte is read or written through 0xA0.
// - partner received page is read-only at offset 0x10, bit 15 resets 0.
// - tx page upper byte at offset 0x0E, lower byte at 0x0F.
// - with automatic mode set, hardware negotiates without software page.
`timescale 1ns/100ps
module npr_regs
  import npr_pkg::*;
#(
  parameter int PORTS = NPR_PORT_CNT
)(
  // clock and reset
  input  wire logic            MCLK,
  input  wire logic            RST,
  // switch register port
  input  wire logic            REG_WR,
  input  wire logic            REG_RD,
  input  wire logic [7:0]      REG_ADDR,
  input  wire logic [7:0]      REG_WDATA,
  output logic      [7:0]      REG_RDATA,
  output logic                 REG_RVALID,
  // auto-negotiation engine, one bit or page per port
  input  wire logic [PORTS-1:0]      AUTO_NEG,
  input  wire logic [PORTS-1:0]      AN_START,
  input  wire logic [PORTS-1:0]      AN_BASE_T,
  input  wire logic [PORTS-1:0]      AN_SENT,
  input  wire logic [PORTS-1:0]      AN_RX_VALID,
  input  wire npr_page_t [PORTS-1:0] AN_RX_PAGE,
  output npr_page_t [PORTS-1:0]      TX_PAGE,
  output logic      [PORTS-1:0]      TX_USE_SW
);

  logic      [7:0]       sel_q, sel_d;
  logic      [7:0]       ofs_q, ofs_d;
  logic      [7:0]       rdata_q, rdata_d;
  logic                  rvalid_q, rvalid_d;
  logic      [PORTS-1:0] use_sw_q, use_sw_d;
  logic      [PORTS-1:0] hit;
  logic      [PORTS-1:0] wr_hi;
  logic      [PORTS-1:0] wr_lo;
  logic      [7:0]       port_byte [PORTS];
  npr_page_t [PORTS-1:0] lp_page;
  logic                  grp_ok;
  logic                  data_wr;

  // every check below runs on the core clock and rests during reset
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  // group match relies on software setting the select first
  assign grp_ok  = sel_q[NPR_GRP_MSB:NPR_GRP_LSB] == NPR_GRP_ENERGY;
  assign data_wr = REG_WR && (REG_ADDR == NPR_ADDR_DATA);

  // one storage slice per port with its own decode and read byte
  for (genvar i = 0; i < PORTS; i++) begin : g_port
    assign hit[i]   = grp_ok &&
                      (sel_q[NPR_PORT_MSB:NPR_PORT_LSB] == NPR_PORT_LOW + 4'(i));
    assign wr_hi[i] = data_wr && hit[i] && (ofs_q == NPR_OFS_TX_HI);
    assign wr_lo[i] = data_wr && hit[i] && (ofs_q == NPR_OFS_TX_LO);

    npr_port u_port (
      .clk         (MCLK),
      .rst         (RST),
      .wr_hi       (wr_hi[i]),
      .wr_lo       (wr_lo[i]),
      .wdata       (REG_WDATA),
      .start       (AN_START[i]),
      .base_toggle (AN_BASE_T[i]),
      .sent        (AN_SENT[i]),
      .rx_valid    (AN_RX_VALID[i]),
      .rx_page     (AN_RX_PAGE[i]),
      .tx_page_q   (TX_PAGE[i]),
      .lp_page_q   (lp_page[i])
    );

    // byte view of the selected indirect offset
    always_comb begin
      port_byte[i] = 8'h00;
      if (hit[i]) begin
        case (ofs_q)
          NPR_OFS_TX_HI: port_byte[i] = TX_PAGE[i][15:8];
          NPR_OFS_TX_LO: port_byte[i] = TX_PAGE[i][7:0];
          NPR_OFS_LP_HI: port_byte[i] = lp_page[i][15:8];
          NPR_OFS_LP_LO: port_byte[i] = lp_page[i][7:0];
          default:       port_byte[i] = 8'h00;
        endcase
      end
    end
  end

  // select, offset and read answer; writes to partner page are dropped
  always_comb begin
    sel_d    = sel_q;
    ofs_d    = ofs_q;
    rdata_d  = 8'h00;
    rvalid_d = REG_RD;
    use_sw_d = ~AUTO_NEG;
    if (REG_WR && REG_ADDR == NPR_ADDR_SEL) begin
      sel_d = REG_WDATA;
    end
    if (REG_WR && REG_ADDR == NPR_ADDR_OFS) begin
      ofs_d = REG_WDATA;
    end
    if (REG_RD) begin
      case (REG_ADDR)
        NPR_ADDR_SEL:  rdata_d = sel_q;
        NPR_ADDR_OFS:  rdata_d = ofs_q;
        NPR_ADDR_DATA: begin
          for (int k = 0; k < PORTS; k++) begin
            rdata_d = rdata_d | port_byte[k];
          end
        end
        default:       rdata_d = 8'h00;
      endcase
    end
  end

  // register stage; every output leaves from here or from a port slice
  always_ff @(posedge MCLK) begin
    if (RST) begin
      sel_q    <= NPR_SEL_RST;
      ofs_q    <= NPR_OFS_RST;
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
      use_sw_q <= '0;
    end else begin
      sel_q    <= sel_d;
      ofs_q    <= ofs_d;
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
      use_sw_q <= use_sw_d;
    end
  end

  assign REG_RDATA  = rdata_q;
  assign REG_RVALID = rvalid_q;
  assign TX_USE_SW  = use_sw_q;

  // checks on port slice 0 and one cover on slice 1, the other slice is the same logic
  property p_more_write;
    wr_hi[0] |=> TX_PAGE[0].more_pages_flag == $past(REG_WDATA[NPR_HI_MORE]);
  endproperty
  a_more_write: assert property (p_more_write) else $error("more pages flag not written");

  property p_reset_vals;
    $past(RST) |-> TX_PAGE[0].message_page_flag && !TX_PAGE[0].more_pages_flag
                   && !TX_PAGE[0].comply_ack_flag && !lp_page[0].more_pages_flag;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("page reset value wrong");

  property p_comply_write;
    wr_hi[0] |=> TX_PAGE[0].comply_ack_flag == $past(REG_WDATA[NPR_HI_COMPLY]);
  endproperty
  a_comply_write: assert property (p_comply_write) else $error("comply flag not written");

  property p_toggle_flip;
    AN_SENT[0] && !AN_START[0] |=> TX_PAGE[0].toggle != $past(TX_PAGE[0].toggle);
  endproperty
  a_toggle_flip: assert property (p_toggle_flip) else $error("toggle did not invert");

  property p_toggle_start;
    AN_START[0] |=> TX_PAGE[0].toggle == !$past(AN_BASE_T[0]);
  endproperty
  a_toggle_start: assert property (p_toggle_start) else $error("first toggle wrong");

  property p_code_lo;
    wr_lo[0] |=> TX_PAGE[0].code[7:0] == $past(REG_WDATA);
  endproperty
  a_code_lo: assert property (p_code_lo) else $error("code low byte not written");

  property p_read_hi;
    REG_RD && REG_ADDR == NPR_ADDR_DATA && hit[0] && ofs_q == NPR_OFS_TX_HI
      |=> REG_RVALID && REG_RDATA == $past(TX_PAGE[0][15:8]);
  endproperty
  a_read_hi: assert property (p_read_hi) else $error("indirect read byte wrong");

  property p_partner;
    AN_RX_VALID[0] |=> lp_page[0] == $past(AN_RX_PAGE[0]) ##1 $stable(lp_page[0]) [*1]
                       or AN_RX_VALID[0];
  endproperty
  a_partner: assert property (p_partner) else $error("partner page not captured");

  property p_other_ofs;
    data_wr && !wr_hi[0] && !wr_lo[0] && !AN_START[0] && !AN_SENT[0]
      |=> $stable(TX_PAGE[0]);
  endproperty
  a_other_ofs: assert property (p_other_ofs) else $error("stray write changed page");

  property p_auto;
    ##1 TX_USE_SW == ~$past(AUTO_NEG);
  endproperty
  a_auto: assert property (p_auto) else $error("software page use wrong");

  property p_ack_zero;
    wr_hi[0] |=> !TX_PAGE[0].ack [*2];
  endproperty
  a_ack_zero: assert property (p_ack_zero) else $error("bit 14 not zero");

  c_write_hi:  cover property (wr_hi[0] ##1 wr_lo[0]);
  c_read_lp:   cover property (REG_RD && hit[1] && ofs_q == NPR_OFS_LP_HI);
  c_exchange:  cover property (AN_START[0] ##[1:4] AN_SENT[0] ##[1:4] AN_SENT[0]);

endmodule : npr_regs

/* verif/npr_lp_model.sv */
// Purpose: stand-in for the negotiation engine and cable partner of each port
// Assumes: events change on the falling edge and last one cycle
// Notes:   page bus shows the inverse once released, stale data never matches
`timescale 1ns/100ps
module npr_lp_model
  import npr_pkg::*;
#(
  parameter int PORTS = 2
)(
  // clock
  input  wire logic             clk,
  // negotiation events per slice
  output logic [PORTS-1:0]      start,
  output logic [PORTS-1:0]      base_t,
  output logic [PORTS-1:0]      sent,
  output logic [PORTS-1:0]      rx_valid,
  output npr_page_t [PORTS-1:0] rx_page
);
  // quiet lines from time zero
  initial begin
    start = '0;
    base_t = '0;
    sent = '0;
    rx_valid = '0;
    rx_page = '0;
  end

  // kind 0 starts a sequence, 1 ends an exchange, 2 hands in a partner page,
  // 3 starts and ends in one cycle, where the start must win
  task pulse(input int kind, input int s, input logic b, input logic [15:0] pg);
    @(negedge clk);
    base_t[s] = b; // base codeword bit 11 held with the start
    rx_page[s] = pg;
    if (kind == 0 || kind == 3) start[s] = 1'b1;
    if (kind == 1 || kind == 3) sent[s] = 1'b1;
    if (kind == 2) rx_valid[s] = 1'b1;
    @(negedge clk);
    start = '0;
    sent = '0;
    rx_valid = '0;
    rx_page[s] = ~pg; // released bus, never the last value
  endtask : pulse
endmodule : npr_lp_model

/* verif/test_autoneg_next_page_regs.sv */
// Purpose: self-checking bench for the indirect next page registers
// Assumes: inputs move on the falling edge, reads answer one cycle later
// Notes:   slice 0 is port 3, slice 1 is port 4
`timescale 1ns/100ps
module test_autoneg_next_page_regs;
  import npr_pkg::*;
  logic              mclk;
  logic              rst;
  logic              wr;
  logic              rd;
  logic [7:0]        addr;
  logic [7:0]        wdata;
  logic [7:0]        rdata;
  logic              rvalid;
  logic [1:0]        auto_neg;
  logic [1:0]        st, bt, sn, rv, use_sw;
  npr_page_t [1:0]   rxp, txp;
  int                miscompares;
  int                check_count;

  npr_regs dut (.MCLK(mclk), .RST(rst), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid), .AUTO_NEG(auto_neg),
    .AN_START(st), .AN_BASE_T(bt), .AN_SENT(sn), .AN_RX_VALID(rv), .AN_RX_PAGE(rxp),
    .TX_PAGE(txp), .TX_USE_SW(use_sw));
  npr_lp_model #(.PORTS(2)) lp (.clk(mclk), .start(st), .base_t(bt), .sent(sn),
    .rx_valid(rv), .rx_page(rxp));

  // 40 MHz clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // one value comparison, reported at once
  task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wr8(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge mclk);
    wr = 1'b0;
  endtask : wr8

  // answer sits in the cycle after the strobe
  task rd8(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk);
    rd = 1'b1;
    addr = a;
    @(negedge mclk);
    rd = 1'b0;
    chk({7'h00, rvalid, rdata}, {8'h01, exp});
  endtask : rd8

  // group 001 and port into select, then the byte offset
  task pick(input logic [3:0] port, input logic [7:0] ofs);
    wr8(NPR_ADDR_SEL, {3'b001, 1'b0, port});
    wr8(NPR_ADDR_OFS, ofs);
  endtask : pick

  task t_reset();
    pick(4'h3, NPR_OFS_TX_HI);
    rd8(NPR_ADDR_DATA, 8'h20);
    wr8(NPR_ADDR_OFS, NPR_OFS_TX_LO);
    rd8(NPR_ADDR_DATA, 8'h00);
    pick(4'h4, NPR_OFS_LP_HI);
    rd8(NPR_ADDR_DATA, 8'h00);
  endtask : t_reset

  // read-only bits 14 and 11 must ignore ones written to them
  task t_tx_write();
    pick(4'h3, NPR_OFS_TX_HI);
    wr8(NPR_ADDR_DATA, 8'hFF);
    chk(txp[0], 16'hB700);
    rd8(NPR_ADDR_DATA, 8'hB7);
    wr8(NPR_ADDR_DATA, 8'h4A);
    rd8(NPR_ADDR_DATA, 8'h02);
    wr8(NPR_ADDR_OFS, NPR_OFS_TX_LO);
    wr8(NPR_ADDR_DATA, 8'h5A);
    rd8(NPR_ADDR_DATA, 8'h5A);
    chk(txp[0], 16'h025A);
  endtask : t_tx_write

  task t_toggle();
    lp.pulse(0, 0, 1'b0, 16'h0000);
    chk(txp[0], 16'h0A5A);
    wr8(NPR_ADDR_OFS, NPR_OFS_TX_HI);
    rd8(NPR_ADDR_DATA, 8'h0A);
    lp.pulse(1, 0, 1'b0, 16'h0000);
    chk({15'h0, txp[0].toggle}, 16'h0000);
    lp.pulse(0, 0, 1'b1, 16'h0000);
    chk({15'h0, txp[0].toggle}, 16'h0000);
    lp.pulse(1, 0, 1'b1, 16'h0000);
    chk({15'h0, txp[0].toggle}, 16'h0001);
    lp.pulse(3, 0, 1'b0, 16'h0000);
    chk({15'h0, txp[0].toggle}, 16'h0001);
  endtask : t_toggle

  // partner page is read-only, writes fall away
  task t_partner();
    lp.pulse(2, 1, 1'b0, 16'h8123);
    pick(4'h4, NPR_OFS_LP_HI);
    rd8(NPR_ADDR_DATA, 8'h81);
    wr8(NPR_ADDR_DATA, 8'h00);
    rd8(NPR_ADDR_DATA, 8'h81);
    wr8(NPR_ADDR_OFS, NPR_OFS_LP_LO);
    rd8(NPR_ADDR_DATA, 8'h23);
  endtask : t_partner

  // bad port, bad group and an unmapped address all read zero
  task t_refuse();
    wr8(NPR_ADDR_SEL, 8'h25);
    rd8(NPR_ADDR_DATA, 8'h00);
    wr8(NPR_ADDR_SEL, 8'h43);
    wr8(NPR_ADDR_DATA, 8'hFF);
    rd8(NPR_ADDR_DATA, 8'h00);
    chk(txp[0], 16'h0A5A);
    rd8(8'h55, 8'h00);
    rd8(NPR_ADDR_SEL, 8'h43);
    chk(txp[1], 16'h2000);
  endtask : t_refuse

  task t_auto();
    @(negedge mclk);
    auto_neg = 2'b01;
    @(negedge mclk);
    chk({14'h0, use_sw}, 16'h0002);
  endtask : t_auto

  task results();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  // tests need under a hundred cycles, the limit allows 4000 cycles
  initial begin
    #100us;
    miscompares++;
    results();
  end

  // reset for four cycles, then the scenarios
  initial begin
    miscompares = 0;
    check_count = 0;
    rst = 1'b1;
    {wr, rd, addr, wdata} = '0;
    auto_neg = 2'b11;
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    t_reset();
    t_tx_write();
    t_toggle();
    t_partner();
    t_refuse();
    t_auto();
    results();
  end
endmodule : test_autoneg_next_page_regs
